// *** logic/tmcr_pkg.sv ***
// package: register map, field layout and encodings of the timer mode/control slice
package tmcr_pkg;
	localparam logic [7:0] TMCR_OFS_CFG = 8'h00;
	localparam logic [7:0] TMCR_OFS_AMODE = 8'h04;
	localparam logic [7:0] TMCR_OFS_BMODE = 8'h08;
	localparam logic [7:0] TMCR_OFS_CTL = 8'h0C;
	localparam logic [7:0] TMCR_OFS_IMR = 8'h18;
	localparam logic [7:0] TMCR_OFS_RIS = 8'h1C;
	localparam logic [7:0] TMCR_OFS_MIS = 8'h20;
	localparam logic [7:0] TMCR_OFS_ICR = 8'h24;
	localparam logic [31:0] TMCR_RESET_VAL = 32'h0000_0000;
	localparam logic [31:0] TMCR_CTL_WMASK = 32'h0000_0F7F;
	localparam logic [31:0] TMCR_MODE_WMASK = 32'h0000_000F;
	localparam logic [31:0] TMCR_CFG_WMASK = 32'h0000_0007;
	localparam logic [31:0] TMCR_IMR_WMASK = 32'h0000_000F;
	localparam int TMCR_CTL_A_EN = 0;
	localparam int TMCR_CTL_A_FREEZE = 1;
	localparam int TMCR_CTL_A_EDGE_LO = 2;
	localparam int TMCR_CTL_CLK_EN = 4;
	localparam int TMCR_CTL_A_TRIG = 5;
	localparam int TMCR_CTL_A_PWMINV = 6;
	localparam int TMCR_CTL_B_EN = 8;
	localparam int TMCR_CTL_B_FREEZE = 9;
	localparam int TMCR_CTL_B_EDGE_LO = 10;
	localparam int TMCR_MODE_CAPTYPE = 2;
	localparam int TMCR_MODE_ALT = 3;
	localparam int TMCR_IM_TIMEOUT = 0;
	localparam int TMCR_IM_CAPMATCH = 1;
	localparam int TMCR_IM_CAPEVENT = 2;
	localparam int TMCR_IM_CLOCK = 3;
	localparam int TMCR_NSRC = 4;
	typedef enum logic [1:0] {TMCR_EDGE_RISE, TMCR_EDGE_FALL, TMCR_EDGE_RSVD, TMCR_EDGE_BOTH} tmcr_edge_t;
	typedef enum logic [2:0] {TMCR_M_OFF, TMCR_M_ONESHOT, TMCR_M_PERIODIC, TMCR_M_CAPTURE, TMCR_M_PWM,
		TMCR_M_CLOCK} tmcr_mode_t;
	typedef enum {TMCR_BUS_IDLE, TMCR_BUS_DONE} tmcr_bus_t;
endpackage : tmcr_pkg

// *** logic/tmcr_mode_decode.sv ***
// module: decodes a mode nibble into a timer operating mode
`timescale 1ns/10ps
module tmcr_mode_decode (
	// mode register and config
	input wire logic [3:0] MODE_NIBBLE,
	input wire logic SPLIT,
	input wire logic CLOCK_CFG,
	// decoded mode
	output tmcr_pkg::tmcr_mode_t MODE
);
	import tmcr_pkg::*;
	always_comb begin
		MODE = TMCR_M_OFF;
		if (CLOCK_CFG) begin
			MODE = TMCR_M_CLOCK;
		end else begin
			case (MODE_NIBBLE[1:0])
				2'h1: MODE = TMCR_M_ONESHOT;
				2'h2: MODE = (SPLIT && MODE_NIBBLE[TMCR_MODE_ALT] && !MODE_NIBBLE[TMCR_MODE_CAPTYPE]) ?
					TMCR_M_PWM : TMCR_M_PERIODIC;
				2'h3: MODE = TMCR_M_CAPTURE;
				default: MODE = TMCR_M_OFF;
			endcase
		end
	end
endmodule : tmcr_mode_decode

// *** logic/tmcr_top.sv ***
// module: timer mode, control and interrupt mask registers on an Avalon-MM slave
`timescale 1ns/10ps
module tmcr_top (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// avalon-mm slave
	input wire logic [7:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [3:0] BYTEENABLE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	// debug halt pin (asynchronous)
	input wire logic DEBUG_HALT,
	// raw events from counters (same clock, one-cycle pulses)
	input wire logic [3:0] EVENT_IN,
	// pwm from counter A
	input wire logic PWM_RAW_A,
	// trigger pulse from counter A
	input wire logic TRIG_RAW_A,
	// controls toward counters
	output logic RUN_A,
	output logic RUN_B,
	output logic [1:0] EDGE_A,
	output logic [1:0] EDGE_B,
	output logic CLOCK_RUN,
	output tmcr_pkg::tmcr_mode_t MODE_A,
	output tmcr_pkg::tmcr_mode_t MODE_B,
	output logic SPLIT_CFG,
	// outputs
	output logic PWM_OUT_A,
	output logic CONV_TRIGGER,
	output logic IRQ
);
	import tmcr_pkg::*;
	logic [31:0] cfg_reg, cfg_next;
	logic [31:0] amode_reg, amode_next;
	logic [31:0] bmode_reg, bmode_next;
	logic [31:0] ctl_reg, ctl_next;
	logic [31:0] imr_reg, imr_next;
	logic [3:0] ris_reg, ris_next;
	logic [31:0] rdata_reg, rdata_next;
	tmcr_bus_t bus_reg, bus_next;
	logic halt_meta_reg, halt_sync_reg;
	logic pwm_reg, trig_reg, irq_reg;
	logic [31:0] bmask;
	logic split, clock_cfg, wr, rd;
	tmcr_mode_t mode_a_dec, mode_b_dec;

	assign bmask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}}, {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
	// one wait cycle, answer on the second edge
	assign WAITREQUEST = (READ || WRITE) && (bus_reg == TMCR_BUS_IDLE);
	assign wr = WRITE && (bus_reg == TMCR_BUS_IDLE);
	assign rd = READ && (bus_reg == TMCR_BUS_IDLE);
	assign split = cfg_reg[2];
	assign clock_cfg = (cfg_reg[2:0] == 3'h1);

	// debug halt synchroniser
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			halt_meta_reg <= 1'b0;
			halt_sync_reg <= 1'b0;
		end else begin
			halt_meta_reg <= DEBUG_HALT;
			halt_sync_reg <= halt_meta_reg;
		end
	end

	// register file next state
	always_comb begin
		cfg_next = cfg_reg;
		amode_next = amode_reg;
		bmode_next = bmode_reg;
		ctl_next = ctl_reg;
		imr_next = imr_reg;
		ris_next = ris_reg | EVENT_IN;
		rdata_next = rdata_reg;
		bus_next = TMCR_BUS_IDLE;
		if (bus_reg == TMCR_BUS_IDLE && (READ || WRITE)) begin
			bus_next = TMCR_BUS_DONE;
		end
		if (wr) begin
			case (ADDRESS)
				TMCR_OFS_CFG: cfg_next = (cfg_reg & ~(bmask & TMCR_CFG_WMASK)) | (WRITEDATA & bmask & TMCR_CFG_WMASK);
				TMCR_OFS_AMODE: amode_next = (amode_reg & ~(bmask & TMCR_MODE_WMASK)) |
					(WRITEDATA & bmask & TMCR_MODE_WMASK);
				TMCR_OFS_BMODE: bmode_next = (bmode_reg & ~(bmask & TMCR_MODE_WMASK)) |
					(WRITEDATA & bmask & TMCR_MODE_WMASK);
				TMCR_OFS_CTL: ctl_next = (ctl_reg & ~(bmask & TMCR_CTL_WMASK)) |
					(WRITEDATA & bmask & TMCR_CTL_WMASK);
				TMCR_OFS_IMR: imr_next = (imr_reg & ~(bmask & TMCR_IMR_WMASK)) |
					(WRITEDATA & bmask & TMCR_IMR_WMASK);
				TMCR_OFS_ICR: ris_next = (ris_reg & ~(WRITEDATA[3:0] & bmask[3:0])) | EVENT_IN;
				default: ;
			endcase
		end
		if (rd) begin
			case (ADDRESS)
				TMCR_OFS_CFG: rdata_next = cfg_reg;
				TMCR_OFS_AMODE: rdata_next = amode_reg;
				TMCR_OFS_BMODE: rdata_next = bmode_reg;
				TMCR_OFS_CTL: rdata_next = ctl_reg & TMCR_CTL_WMASK;
				TMCR_OFS_IMR: rdata_next = imr_reg;
				TMCR_OFS_RIS: rdata_next = {28'h0000000, ris_reg};
				TMCR_OFS_MIS: rdata_next = {28'h0000000, ris_reg & imr_reg[3:0]};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cfg_reg <= TMCR_RESET_VAL;
			amode_reg <= TMCR_RESET_VAL;
			bmode_reg <= TMCR_RESET_VAL;
			ctl_reg <= TMCR_RESET_VAL;
			imr_reg <= TMCR_RESET_VAL;
			ris_reg <= 4'h0;
			rdata_reg <= TMCR_RESET_VAL;
			bus_reg <= TMCR_BUS_IDLE;
		end else begin
			cfg_reg <= cfg_next;
			amode_reg <= amode_next;
			bmode_reg <= bmode_next;
			ctl_reg <= ctl_next;
			imr_reg <= imr_next;
			ris_reg <= ris_next;
			rdata_reg <= rdata_next;
			bus_reg <= bus_next;
		end
	end
	assign READDATA = rdata_reg;

	// mode decoders
	tmcr_mode_decode u_dec_a (
		.MODE_NIBBLE(amode_reg[3:0]),
		.SPLIT(split),
		.CLOCK_CFG(clock_cfg),
		.MODE(mode_a_dec)
	);
	tmcr_mode_decode u_dec_b (
		.MODE_NIBBLE(bmode_reg[3:0]),
		.SPLIT(split),
		.CLOCK_CFG(clock_cfg),
		.MODE(mode_b_dec)
	);
	// whole 32-bit counter follows A's mode
	assign MODE_A = mode_a_dec;
	assign MODE_B = split ? mode_b_dec : mode_a_dec;
	assign SPLIT_CFG = split;

	// run controls: freeze only when halted
	assign RUN_A = ctl_reg[TMCR_CTL_A_EN] && !(halt_sync_reg && ctl_reg[TMCR_CTL_A_FREEZE]);
	assign RUN_B = ctl_reg[TMCR_CTL_B_EN] && !(halt_sync_reg && ctl_reg[TMCR_CTL_B_FREEZE]);
	assign EDGE_A = ctl_reg[TMCR_CTL_A_EDGE_LO +: 2];
	assign EDGE_B = ctl_reg[TMCR_CTL_B_EDGE_LO +: 2];
	assign CLOCK_RUN = ctl_reg[TMCR_CTL_CLK_EN];

	// registered outputs
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pwm_reg <= 1'b0;
			trig_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			pwm_reg <= PWM_RAW_A ^ ctl_reg[TMCR_CTL_A_PWMINV];
			trig_reg <= TRIG_RAW_A && ctl_reg[TMCR_CTL_A_TRIG];
			irq_reg <= |(ris_reg & imr_reg[3:0]);
		end
	end
	assign PWM_OUT_A = pwm_reg;
	assign CONV_TRIGGER = trig_reg;
	assign IRQ = irq_reg;

	// checks
	property p_trig_gated;
		@(posedge REF_CLK) disable iff (RST) !ctl_reg[TMCR_CTL_A_TRIG] |=> !CONV_TRIGGER;
	endproperty
	a_trig_gated: assert property (p_trig_gated) else $error("trigger while disabled");
	property p_pwm_inv;
		@(posedge REF_CLK) disable iff (RST) 1'b1 |=> PWM_OUT_A == ($past(PWM_RAW_A) ^ $past(ctl_reg[6]));
	endproperty
	a_pwm_inv: assert property (p_pwm_inv) else $error("pwm polarity wrong");
	property p_no_halt_run;
		@(posedge REF_CLK) disable iff (RST) !halt_sync_reg |-> (RUN_A == ctl_reg[0]) && (RUN_B == ctl_reg[8]);
	endproperty
	a_no_halt_run: assert property (p_no_halt_run) else $error("freeze acted while running");
	property p_freeze_a;
		@(posedge REF_CLK) disable iff (RST) halt_sync_reg && ctl_reg[1] |-> !RUN_A;
	endproperty
	a_freeze_a: assert property (p_freeze_a) else $error("timer A not frozen");
	property p_freeze_b;
		@(posedge REF_CLK) disable iff (RST) halt_sync_reg && ctl_reg[9] |-> !RUN_B;
	endproperty
	a_freeze_b: assert property (p_freeze_b) else $error("timer B not frozen");
	property p_bit7;
		@(posedge REF_CLK) disable iff (RST) rd && ADDRESS == TMCR_OFS_CTL |=> !READDATA[7];
	endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 not zero");
	property p_mode32;
		@(posedge REF_CLK) disable iff (RST) !split |-> MODE_B == MODE_A;
	endproperty
	a_mode32: assert property (p_mode32) else $error("B mode used in 32-bit");
	property p_raw_set;
		@(posedge REF_CLK) disable iff (RST) EVENT_IN[0] |=> ris_reg[0];
	endproperty
	a_raw_set: assert property (p_raw_set) else $error("raw status lost");
	property p_irq;
		@(posedge REF_CLK) disable iff (RST) |(ris_reg & imr_reg[3:0]) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_mask_reset;
		@(posedge REF_CLK) $fell(RST) |-> imr_reg == 32'h0000_0000;
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("mask not reset");

	// mode decode in split, 32-bit and clock configs
	property p_mb_oneshot;
		@(posedge REF_CLK) disable iff (RST) split && bmode_reg[1:0] == 2'h1 |-> MODE_B == TMCR_M_ONESHOT;
	endproperty
	a_mb_oneshot: assert property (p_mb_oneshot) else $error("B one-shot wrong");
	property p_mb_periodic;
		@(posedge REF_CLK) disable iff (RST)
			split && bmode_reg[1:0] == 2'h2 && !bmode_reg[TMCR_MODE_ALT] |-> MODE_B == TMCR_M_PERIODIC;
	endproperty
	a_mb_periodic: assert property (p_mb_periodic) else $error("B periodic wrong");
	property p_mb_capture;
		@(posedge REF_CLK) disable iff (RST) split && bmode_reg[1:0] == 2'h3 |-> MODE_B == TMCR_M_CAPTURE;
	endproperty
	a_mb_capture: assert property (p_mb_capture) else $error("B capture wrong");
	property p_mb_rsvd;
		@(posedge REF_CLK) disable iff (RST) split && bmode_reg[1:0] == 2'h0 |-> MODE_B == TMCR_M_OFF;
	endproperty
	a_mb_rsvd: assert property (p_mb_rsvd) else $error("B reserved mode runs");
	property p_mb_pwm;
		@(posedge REF_CLK) disable iff (RST) split && bmode_reg[3:0] == 4'hA |-> MODE_B == TMCR_M_PWM;
	endproperty
	a_mb_pwm: assert property (p_mb_pwm) else $error("B pwm decode wrong");
	property p_m32_follow;
		@(posedge REF_CLK) disable iff (RST)
			cfg_reg[2:0] == 3'h0 && amode_reg[1:0] == 2'h1 |-> MODE_B == TMCR_M_ONESHOT;
	endproperty
	a_m32_follow: assert property (p_m32_follow) else $error("32-bit mode not from A");
	property p_clock_cfg;
		@(posedge REF_CLK) disable iff (RST) cfg_reg[2:0] == 3'h1 |-> MODE_A == TMCR_M_CLOCK;
	endproperty
	a_clock_cfg: assert property (p_clock_cfg) else $error("clock config not decoded");
	property p_split_out;
		@(posedge REF_CLK) disable iff (RST) SPLIT_CFG == cfg_reg[2];
	endproperty
	a_split_out: assert property (p_split_out) else $error("split flag wrong");

	// control fields
	property p_edge_a;
		@(posedge REF_CLK) disable iff (RST) EDGE_A == ctl_reg[3:2];
	endproperty
	a_edge_a: assert property (p_edge_a) else $error("edge A wrong");
	property p_edge_b;
		@(posedge REF_CLK) disable iff (RST) EDGE_B == ctl_reg[11:10];
	endproperty
	a_edge_b: assert property (p_edge_b) else $error("edge B wrong");
	property p_clk_run;
		@(posedge REF_CLK) disable iff (RST) CLOCK_RUN == ctl_reg[4];
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("clock run wrong");
	property p_a_off;
		@(posedge REF_CLK) disable iff (RST) !ctl_reg[0] |-> !RUN_A;
	endproperty
	a_a_off: assert property (p_a_off) else $error("timer A runs disabled");
	property p_b_off;
		@(posedge REF_CLK) disable iff (RST) !ctl_reg[8] |-> !RUN_B;
	endproperty
	a_b_off: assert property (p_b_off) else $error("timer B runs disabled");
	property p_a_nofreeze;
		@(posedge REF_CLK) disable iff (RST) ctl_reg[0] && !ctl_reg[1] |-> RUN_A;
	endproperty
	a_a_nofreeze: assert property (p_a_nofreeze) else $error("timer A stopped");
	property p_b_nofreeze;
		@(posedge REF_CLK) disable iff (RST) ctl_reg[8] && !ctl_reg[9] |-> RUN_B;
	endproperty
	a_b_nofreeze: assert property (p_b_nofreeze) else $error("timer B stopped");
	property p_trig_on;
		@(posedge REF_CLK) disable iff (RST) ctl_reg[5] && TRIG_RAW_A |=> CONV_TRIGGER;
	endproperty
	a_trig_on: assert property (p_trig_on) else $error("trigger lost");
	property p_ctl_b7;
		@(posedge REF_CLK) disable iff (RST) !ctl_reg[7];
	endproperty
	a_ctl_b7: assert property (p_ctl_b7) else $error("bit 7 stored");

	// mask, status and wait request
	property p_imr_hi;
		@(posedge REF_CLK) disable iff (RST) imr_reg[31:4] == 28'h0000000;
	endproperty
	a_imr_hi: assert property (p_imr_hi) else $error("mask upper bits set");
	property p_irq_off;
		@(posedge REF_CLK) disable iff (RST) (ris_reg & imr_reg[3:0]) == 4'h0 |=> !IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while masked");
	property p_ris_read;
		@(posedge REF_CLK) disable iff (RST) rd && ADDRESS == TMCR_OFS_RIS |=> READDATA[3:0] == $past(ris_reg);
	endproperty
	a_ris_read: assert property (p_ris_read) else $error("raw read wrong");
	property p_mis_read;
		@(posedge REF_CLK) disable iff (RST)
			rd && ADDRESS == TMCR_OFS_MIS |=> READDATA[3:0] == $past(ris_reg & imr_reg[3:0]);
	endproperty
	a_mis_read: assert property (p_mis_read) else $error("masked read wrong");
	property p_wait_first;
		@(posedge REF_CLK) disable iff (RST) (READ || WRITE) && bus_reg == TMCR_BUS_IDLE |-> WAITREQUEST;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
	property p_wait_done;
		@(posedge REF_CLK) disable iff (RST) bus_reg == TMCR_BUS_DONE |-> !WAITREQUEST;
	endproperty
	a_wait_done: assert property (p_wait_done) else $error("wait held too long");
endmodule : tmcr_top

// *** testbench/tmcr_far_model.sv ***
// far side model: converter that consumes the timer trigger
`timescale 1ns/10ps
module tmcr_far_model (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// converter controls and trigger
	input wire logic CONV_TRIGGER,
	input wire logic CONV_ON,
	input wire logic CONV_SEL,
	// triggers taken
	output logic [7:0] CONV_HITS
);
	logic [7:0] hits_next;
	always_comb begin
		hits_next = CONV_HITS;
		if (CONV_TRIGGER && CONV_ON && CONV_SEL) hits_next = CONV_HITS + 8'h01;
	end
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) CONV_HITS <= 8'h00;
		else CONV_HITS <= hits_next;
	end
endmodule : tmcr_far_model

// *** testbench/tmcr_top_bench.sv ***
// testbench: register access, control outputs, modes and interrupt masking
`timescale 1ns/10ps
module tmcr_top_bench;
	import tmcr_pkg::*;
	logic clk = 0, rst = 1, rd = 0, wr = 0, halt = 0, praw = 0, traw = 0, c_on = 0, c_sel = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] be = 4'hF, ev = 4'h0;
	logic [31:0] wd = 32'h0, rdat, d;
	logic wreq, run_a, run_b, clk_run, split, pwm, trig, irq;
	logic [1:0] e_a, e_b;
	tmcr_mode_t m_a, m_b;
	logic [7:0] hits;
	int n_fail = 0, n_tests = 0;
	tmcr_top dut (.REF_CLK(clk), .RST(rst), .ADDRESS(adr), .READ(rd), .WRITE(wr), .BYTEENABLE(be),
		.WRITEDATA(wd), .READDATA(rdat), .WAITREQUEST(wreq), .DEBUG_HALT(halt), .EVENT_IN(ev),
		.PWM_RAW_A(praw), .TRIG_RAW_A(traw), .RUN_A(run_a), .RUN_B(run_b), .EDGE_A(e_a), .EDGE_B(e_b),
		.CLOCK_RUN(clk_run), .MODE_A(m_a), .MODE_B(m_b), .SPLIT_CFG(split), .PWM_OUT_A(pwm),
		.CONV_TRIGGER(trig), .IRQ(irq));
	tmcr_far_model far (.REF_CLK(clk), .RST(rst), .CONV_TRIGGER(trig), .CONV_ON(c_on), .CONV_SEL(c_sel),
		.CONV_HITS(hits));
	initial begin
		forever #25 clk = ~clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge clk);
		adr <= a;
		wd <= v;
		wr <= w;
		rd <= !w;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		if (k >= 50) n_fail++;
		d = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : acc
	task tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : tick
	task pulse(input int i);
		@(posedge clk);
		ev <= 4'h1 << i;
		@(posedge clk);
		ev <= 4'h0;
		tick(3);
	endtask : pulse
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		give_verdict;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		acc(0, TMCR_OFS_CTL, 0);
		chk(d, 32'h0);
		acc(0, TMCR_OFS_IMR, 0);
		chk(d, 32'h0);
		acc(1, TMCR_OFS_CTL, 32'hFFFF_FFFF);
		acc(0, TMCR_OFS_CTL, 0);
		chk(d, 32'h0000_0F7F);
		tick(1);
		chk({run_a, run_b, clk_run, e_a, e_b}, 32'h7F);
		@(posedge clk);
		halt <= 1'b1;
		tick(4);
		chk({run_a, run_b}, 32'h0);
		acc(1, TMCR_OFS_CTL, 32'h0000_0F7D);
		tick(1);
		chk({run_a, run_b}, 32'h2);
		@(posedge clk);
		halt <= 1'b0;
		tick(4);
		chk({run_a, run_b}, 32'h3);
		acc(1, TMCR_OFS_CTL, 32'h0000_0405);
		tick(1);
		chk({e_a, e_b, run_a, run_b, clk_run}, 32'h2C);
		$display("control test done");
		@(posedge clk);
		praw <= 1'b1;
		traw <= 1'b1;
		c_on <= 1'b1;
		acc(1, TMCR_OFS_CTL, 32'h0000_0060);
		tick(2);
		chk({pwm, trig}, 32'h1);
		chk(hits, 32'h0);
		@(posedge clk);
		c_sel <= 1'b1;
		tick(2);
		chk(hits != 8'h00, 32'h1);
		acc(1, TMCR_OFS_CTL, 32'h0);
		tick(2);
		chk({pwm, trig}, 32'h2);
		$display("output test done");
		acc(1, TMCR_OFS_CFG, 32'h4);
		for (int i = 1; i < 4; i++) begin
			acc(1, TMCR_OFS_BMODE, i);
			tick(1);
			chk(m_b, i);
		end
		acc(1, TMCR_OFS_BMODE, 32'hA);
		tick(1);
		chk(m_b, TMCR_M_PWM);
		chk(split, 32'h1);
		acc(1, TMCR_OFS_AMODE, 32'h1);
		acc(1, TMCR_OFS_CFG, 32'h0);
		acc(1, TMCR_OFS_BMODE, 32'h3);
		tick(1);
		chk(m_a, TMCR_M_ONESHOT);
		chk(m_b, TMCR_M_ONESHOT);
		chk(split, 32'h0);
		acc(1, TMCR_OFS_CFG, 32'h1);
		tick(1);
		chk({m_a, m_b}, {TMCR_M_CLOCK, TMCR_M_CLOCK});
		$display("mode test done");
		for (int i = 0; i < 4; i++) begin
			acc(1, TMCR_OFS_IMR, 0);
			pulse(i);
			chk(irq, 32'h0);
			acc(0, TMCR_OFS_RIS, 0);
			chk(d, 32'h1 << i);
			acc(1, TMCR_OFS_ICR, 32'h1 << i);
			acc(1, TMCR_OFS_IMR, 32'h1 << i);
			pulse(i);
			chk(irq, 32'h1);
			acc(0, TMCR_OFS_MIS, 0);
			chk(d, 32'h1 << i);
			acc(0, TMCR_OFS_IMR, 0);
			chk(d, 32'h1 << i);
			acc(1, TMCR_OFS_ICR, 32'h1 << i);
			tick(3);
			chk(irq, 32'h0);
		end
		acc(0, 8'h40, 0);
		chk(d, 32'h0);
		$display("interrupt test done");
		give_verdict;
	end
endmodule : tmcr_top_bench
